// *** design/usdp_data_port.sv ***
// usdp_data_port: serial port with receive/transmit fifos reached through a 16-word alias window
// assumes a single-cycle register port, async serial line pins outside the clock domain
// How it works
// - the receive buffer and transmit holding path answer at all sixteen word addresses of the window.
// - a window read gives the received byte in bits 7:0, from the plain or the infrared input.
// - the byte read is meaningful only while rx_data_ready is set in line_status.
// - with fifos off an unread byte is overwritten by the next character and overrun is flagged.
// - with fifos on a window read returns the head of the receive fifo.
// - with the receive fifo full an arriving character is dropped, the fifo kept, overrun flagged.
// - a window write supplies the next character for the plain output or the low-active ir output.
// - with fifos off a single write clears tx_holding_empty.
// - with fifos off further writes before tx_holding_empty returns overwrite the pending byte.
// - with fifos on the transmit fifo takes DEPTH characters before it reports full.
// - a write to a full transmit fifo is dropped and leaves the fifo untouched.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module usdp_data_port
   import usdp_pkg::*;
#(
   parameter int DEPTH   = FIFO_DEPTH,  // power of two
   parameter int BAUD_DV = OVS_DIV      // clocks per oversample tick
) (
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   output logic             o_irq,
   input  wire logic        i_sin,
   input  wire logic        i_sir_in,
   output logic             o_sout,
   output logic             o_sir_out_n
);

   // ************************************************************
   // state
   // ************************************************************
   // DEPTH must be a power of two so the pointers wrap without compare logic
   localparam int PW = $clog2(DEPTH);
   localparam int DW = $clog2(BAUD_DV + 1);
   localparam logic [PW:0]   FULL_CNT  = (PW+1)'(DEPTH);
   localparam logic [DW-1:0] DIV_LAST  = DW'(BAUD_DV - 1);
   localparam logic [3:0]    TK_LAST   = 4'(OVS_TICKS - 1);
   localparam logic [3:0]    TK_SAMPLE = 4'(SAMPLE_TICK);
   localparam logic [3:0]    TK_IR     = 4'(IR_PULSE_TK);
   localparam logic [3:0]    BIT_LAST  = 4'(FRAME_BITS - 1);

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } usdp_rx_st_t;

   typedef struct packed {
      logic [DEPTH-1:0][7:0] rx_mem;
      logic [PW-1:0]         rx_wp;
      logic [PW-1:0]         rx_rp;
      logic [PW:0]           rx_cnt;
      logic [DEPTH-1:0][7:0] tx_mem;
      logic [PW-1:0]         tx_wp;
      logic [PW-1:0]         tx_rp;
      logic [PW:0]           tx_cnt;
      logic                  fifo_en;
      logic                  ir_mode;
      logic                  overrun;
      logic [EV_W-1:0]       ev_stat;
      logic [EV_W-1:0]       ev_mask;
      logic [31:0]           rdata;
      logic                  irq;
      logic [DW-1:0]         div;
      logic                  tick;
      logic [1:0]            sin_sy;
      logic [1:0]            sir_sy;
      usdp_rx_st_t           rx_st;
      logic [3:0]            rx_tk;
      logic [2:0]            rx_bit;
      logic                  rx_samp;
      logic [7:0]            rx_shift;
      logic                  tx_busy;
      logic [3:0]            tx_tk;
      logic [3:0]            tx_bit;
      logic [9:0]            tx_shift;
      logic                  sout;
      logic                  sir_n;
   } usdp_state_t;

   usdp_state_t st_r;
   usdp_state_t st_nxt;

   // ************************************************************
   // next-state logic
   // ************************************************************
   // one pass: register reads, receive path, transmit path, register writes, events, outputs
   always_comb begin
      logic            win_hit;
      logic            line_zero;
      logic            rx_push;
      logic [7:0]      rx_byte;
      logic [EV_W-1:0] ev;
      logic [EV_W-1:0] w1c;
      logic [7:0]      ls;
      logic            tx_pop;
      logic            tx_bitv;
      win_hit   = 1'b0;
      line_zero = 1'b0;
      rx_push   = 1'b0;
      rx_byte   = BYTE_RST;
      ev        = '0;
      w1c       = '0;
      ls        = BYTE_RST;
      tx_pop    = 1'b0;
      tx_bitv   = 1'b1;
      st_nxt    = st_r;

      // all sixteen word addresses of the window decode to one data path
      win_hit = (i_addr >= ALIAS_FIRST) && (i_addr <= ALIAS_LAST)
                && (i_addr[1:0] == 2'b00);

      // line status as seen by software before this cycle's updates
      ls[LS_DREADY]  = (st_r.rx_cnt != '0);
      ls[LS_OVERRUN] = st_r.overrun;
      ls[LS_TXHOLD]  = (st_r.tx_cnt == '0);
      ls[LS_TEMT]    = (st_r.tx_cnt == '0) && !st_r.tx_busy;

      // oversample tick: one-cycle enable every BAUD_DV clocks
      // one divider serves both directions, so rx and tx share the tick phase
      st_nxt.tick = 1'b0;
      if (st_r.div == DIV_LAST) begin
         st_nxt.div  = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.div = st_r.div + DW'(1);
      end

      // two-stage synchronisers for both line inputs
      st_nxt.sin_sy = {st_r.sin_sy[0], i_sin};
      st_nxt.sir_sy = {st_r.sir_sy[0], i_sir_in};

      // ---------------- register reads, data one cycle later ----------------
      st_nxt.rdata = '0;
      if (i_rd) begin
         if (win_hit) begin
            // head of the fifo, or the single buffer when fifos are off
            st_nxt.rdata[7:0] = st_r.rx_mem[st_r.rx_rp];
            if (st_r.rx_cnt != '0) begin
               // popping here is what the primary location does too
               st_nxt.rx_rp  = st_r.rx_rp + PW'(1);
               st_nxt.rx_cnt = st_r.rx_cnt - (PW+1)'(1);
            end
         end else if (i_addr == LINE_STAT_A) begin
            st_nxt.rdata[7:0] = ls;
            st_nxt.overrun    = 1'b0;  // clear on read, a new overrun below wins
         end else if (i_addr == FIFO_CTRL_A) begin
            st_nxt.rdata[FC_ENABLE] = st_r.fifo_en;
         end else if (i_addr == MODE_CTRL_A) begin
            st_nxt.rdata[MC_IR_MODE] = st_r.ir_mode;
         end else if (i_addr == IRQ_STAT_A) begin
            st_nxt.rdata[EV_W-1:0] = st_r.ev_stat;
         end else if (i_addr == IRQ_MASK_A) begin
            st_nxt.rdata[EV_W-1:0] = st_r.ev_mask;
         end
      end

      // ---------------- receiver ----------------
      // plain line idles high; an infrared pulse (high) marks a zero bit
      // no framing check: a low stop bit still stores the byte
      line_zero = st_r.ir_mode ? st_r.sir_sy[1] : !st_r.sin_sy[1];
      if (st_r.tick) begin
         st_nxt.rx_tk = st_r.rx_tk + 4'(1);
         // a zero seen anywhere in the window counts for infrared, since pulses are short
         if (st_r.ir_mode) begin
            if (st_r.rx_tk == '0) begin
               st_nxt.rx_samp = !line_zero;
            end else if (line_zero) begin
               st_nxt.rx_samp = 1'b0;
            end
         end else if (st_r.rx_tk == TK_SAMPLE) begin
            st_nxt.rx_samp = !line_zero;
         end
         case (st_r.rx_st)
            RX_IDLE: begin
               st_nxt.rx_tk = '0;
               if (line_zero) begin
                  st_nxt.rx_st = RX_START;
               end
            end
            RX_START: begin
               if (st_r.rx_tk == TK_LAST) begin
                  st_nxt.rx_st  = RX_DATA;
                  st_nxt.rx_bit = '0;
               end
            end
            RX_DATA: begin
               if (st_r.rx_tk == TK_LAST) begin
                  st_nxt.rx_shift = {st_r.rx_samp, st_r.rx_shift[7:1]};
                  st_nxt.rx_bit   = st_r.rx_bit + 3'(1);
                  if (st_r.rx_bit == 3'h7) begin
                     st_nxt.rx_st = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               // leave at mid stop bit so a following start edge is not missed
               if (st_r.rx_tk == TK_SAMPLE) begin
                  rx_push      = 1'b1;
                  rx_byte      = st_r.rx_shift;
                  st_nxt.rx_st = RX_IDLE;
               end
            end
            default: begin
               st_nxt.rx_st = RX_IDLE;
            end
         endcase
      end

      // store the new character after any pop of this cycle
      if (rx_push) begin
         if (!st_r.fifo_en && (st_nxt.rx_cnt != '0)) begin
            // single buffer still unread: overwrite it and flag the loss
            st_nxt.rx_mem[st_nxt.rx_rp] = rx_byte;
            st_nxt.overrun              = 1'b1;
            ev[EV_OVR]                  = 1'b1;
            ev[EV_RX]                   = 1'b1;
         end else if (st_r.fifo_en && (st_nxt.rx_cnt == FULL_CNT)) begin
            // fifo full: keep what is stored, drop the newcomer
            st_nxt.overrun = 1'b1;
            ev[EV_OVR]     = 1'b1;
         end else begin
            st_nxt.rx_mem[st_nxt.rx_wp] = rx_byte;
            st_nxt.rx_wp                = st_nxt.rx_wp + PW'(1);
            st_nxt.rx_cnt               = st_nxt.rx_cnt + (PW+1)'(1);
            ev[EV_RX]                   = 1'b1;
         end
      end

      // ---------------- transmitter ----------------
      if (st_r.tick) begin
         if (st_r.tx_busy) begin
            st_nxt.tx_tk = st_r.tx_tk + 4'(1);
            if (st_r.tx_tk == TK_LAST) begin
               st_nxt.tx_shift = {1'b1, st_r.tx_shift[9:1]};
               st_nxt.tx_bit   = st_r.tx_bit + 4'(1);
               if (st_r.tx_bit == BIT_LAST) begin
                  st_nxt.tx_busy = 1'b0;
               end
            end
         end else if (st_r.tx_cnt != '0) begin
            // frame = stop, data, start; sent lsb first
            tx_pop          = 1'b1;
            st_nxt.tx_busy  = 1'b1;
            st_nxt.tx_tk    = '0;
            st_nxt.tx_bit   = '0;
            st_nxt.tx_shift = {1'b1, st_r.tx_mem[st_r.tx_rp], 1'b0};
            st_nxt.tx_rp    = st_r.tx_rp + PW'(1);
            st_nxt.tx_cnt   = st_r.tx_cnt - (PW+1)'(1);
            if (st_r.tx_cnt == (PW+1)'(1)) begin
               ev[EV_TXHOLD] = 1'b1;
            end
         end
      end

      // ---------------- register writes ----------------
      if (i_wr) begin
         if (win_hit) begin
            if (!st_r.fifo_en && (st_nxt.tx_cnt != '0)) begin
               // pending byte not yet taken by the shifter: replace it
               st_nxt.tx_mem[st_nxt.tx_rp] = i_wdata[7:0];
               if (tx_pop) begin
                  // the shifter took the old byte this cycle; nothing else pending
                  st_nxt.tx_mem[st_nxt.tx_rp] = i_wdata[7:0];
               end
            end else if (st_nxt.tx_cnt != FULL_CNT) begin
               st_nxt.tx_mem[st_nxt.tx_wp] = i_wdata[7:0];
               st_nxt.tx_wp                = st_nxt.tx_wp + PW'(1);
               st_nxt.tx_cnt               = st_nxt.tx_cnt + (PW+1)'(1);
               ev[EV_TXHOLD]               = 1'b0;
            end
            // a full fifo drops the write and leaves the contents alone
            // the drop is silent, so software has to respect tx_holding_empty
         end else if (i_addr == FIFO_CTRL_A) begin
            // changing mode empties both paths so pointers never disagree
            st_nxt.fifo_en = i_wdata[FC_ENABLE];
            st_nxt.rx_wp   = '0;
            st_nxt.rx_rp   = '0;
            st_nxt.rx_cnt  = '0;
            st_nxt.tx_wp   = '0;
            st_nxt.tx_rp   = '0;
            st_nxt.tx_cnt  = '0;
         end else if (i_addr == MODE_CTRL_A) begin
            st_nxt.ir_mode = i_wdata[MC_IR_MODE];
         end else if (i_addr == IRQ_STAT_A) begin
            w1c = i_wdata[EV_W-1:0];
         end else if (i_addr == IRQ_MASK_A) begin
            st_nxt.ev_mask = i_wdata[EV_W-1:0];
         end
      end

      // ---------------- events and outputs ----------------
      // a set in the same cycle as its clear survives
      st_nxt.ev_stat = (st_r.ev_stat & ~w1c) | ev;
      st_nxt.irq     = |(st_nxt.ev_stat & st_nxt.ev_mask);

      tx_bitv       = st_nxt.tx_busy ? st_nxt.tx_shift[0] : 1'b1;
      st_nxt.sout   = st_nxt.ir_mode ? 1'b1 : tx_bitv;
      // ir output pulses low for the first 3/16 of each zero bit
      st_nxt.sir_n  = !(st_nxt.ir_mode && !tx_bitv && (st_nxt.tx_tk < TK_IR));
   end

   // ************************************************************
   // state register
   // ************************************************************
   // reset leaves the lines idle, fifos off and empty, all events masked
   // synchronisers reset to the idle level of their pins so no false start follows
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         st_r         <= '0;
         st_r.ev_mask <= MASK_RST;
         st_r.sin_sy  <= 2'b11;
         st_r.rx_samp <= 1'b1;
         st_r.tx_shift <= 10'h3FF;
         st_r.sout    <= 1'b1;
         st_r.sir_n   <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // every output is a bit of the state register, no logic after the flops
   assign o_rdata     = st_r.rdata;
   assign o_irq       = st_r.irq;
   assign o_sout      = st_r.sout;
   assign o_sir_out_n = st_r.sir_n;

endmodule : usdp_data_port

// *** inc/usdp_pkg.sv ***
// usdp_pkg: constants shared by the serial data-port block
// assumes a 100 MHz system clock and a byte-wide register map in the low bits of a 32-bit word
package usdp_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_HZ       = 100_000_000;  // system clock rate
   localparam int BAUD_RATE    = 115_200;      // default line rate
   localparam int OVS_TICKS    = 16;           // oversample ticks per bit
   localparam int OVS_DIV      = CLK_HZ / (BAUD_RATE * OVS_TICKS);
   localparam int SAMPLE_TICK  = 8;            // mid-bit sample point
   localparam int IR_PULSE_TK  = 3;            // infrared pulse is 3/16 of a bit
   localparam int FRAME_BITS   = 10;           // start, 8 data, stop
   localparam int FIFO_DEPTH   = 16;           // default fifo depth

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [31:0] ALIAS_FIRST  = 32'h5000_1030; // shadow_rx_tx_data_0
   localparam logic [31:0] ALIAS_LAST   = 32'h5000_106C; // shadow_rx_tx_data_15
   localparam logic [31:0] SHADOW_13    = 32'h5000_1064; // shadow_rx_tx_data_13
   localparam logic [31:0] SHADOW_14    = 32'h5000_1068; // shadow_rx_tx_data_14
   localparam logic [31:0] FIFO_CTRL_A  = 32'h5000_1008; // fifo_control
   localparam logic [31:0] LINE_STAT_A  = 32'h5000_1014; // line_status
   localparam logic [31:0] MODE_CTRL_A  = 32'h5000_1080; // infrared mode select
   localparam logic [31:0] IRQ_STAT_A   = 32'h5000_1084; // sticky event bits
   localparam logic [31:0] IRQ_MASK_A   = 32'h5000_1088; // event enables

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int FC_ENABLE    = 0;  // fifo_control: fifos enabled
   localparam int LS_DREADY    = 0;  // line_status: rx_data_ready
   localparam int LS_OVERRUN   = 1;  // line_status: overrun error
   localparam int LS_TXHOLD    = 5;  // line_status: tx_holding_empty
   localparam int LS_TEMT      = 6;  // line_status: transmitter idle and empty
   localparam int MC_IR_MODE   = 0;  // mode control: infrared
   localparam int EV_RX        = 0;  // event: character received
   localparam int EV_OVR       = 1;  // event: overrun
   localparam int EV_TXHOLD    = 2;  // event: transmit holding empties
   localparam int EV_W         = 3;  // number of events
   localparam logic [7:0]      BYTE_RST = 8'h00;
   localparam logic [EV_W-1:0] MASK_RST = 3'h0;

endpackage : usdp_pkg

// *** test/usdp_data_port_props.sv ***
// usdp_data_port_props: port-level checks of the serial data port
// assumes it is bound onto usdp_data_port: one clock, async high reset
`timescale 1ns/1ns
module usdp_data_port_props
   import usdp_pkg::*;
#(
   parameter int DEPTH   = FIFO_DEPTH,
   parameter int BAUD_DV = OVS_DIV
) (
   input wire logic        i_mclk,
   input wire logic        i_reset,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        o_irq,
   input wire logic        i_sin,
   input wire logic        i_sir_in,
   input wire logic        o_sout,
   input wire logic        o_sir_out_n
);
   localparam int BIT = OVS_TICKS * BAUD_DV;
   logic            ir_r, sent_r, win_a, map_a;
   logic [EV_W-1:0] mask_r;
   int              low_r, pulse_r;
   // address decode seen from the bus side
   assign win_a = i_addr >= ALIAS_FIRST && i_addr <= ALIAS_LAST && i_addr[1:0] == 2'h0;
   assign map_a = win_a || i_addr inside {FIFO_CTRL_A, LINE_STAT_A, MODE_CTRL_A,
                                          IRQ_STAT_A, IRQ_MASK_A};
   // mirror of mode and mask; run lengths of low line levels
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         ir_r    <= 1'b0;
         sent_r  <= 1'b0;
         mask_r  <= MASK_RST;
         low_r   <= 0;
         pulse_r <= 0;
      end else begin
         if (i_wr && i_addr == MODE_CTRL_A) ir_r <= i_wdata[MC_IR_MODE];
         if (i_wr && i_addr == IRQ_MASK_A) mask_r <= i_wdata[EV_W-1:0];
         if (i_wr && win_a) sent_r <= 1'b1;
         low_r   <= o_sout ? 0 : low_r + 1;
         pulse_r <= o_sir_out_n ? 0 : pulse_r + 1;
      end
   end
   a_unmapped_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
      !$past(i_rd) || !$past(map_a) |-> o_rdata == 32'h0) else $error("stray read data");
   a_window_byte: assert property (@(posedge i_mclk) disable iff (i_reset)
      $past(i_rd) && $past(win_a) |-> o_rdata[31:8] == 24'h0) else $error("upper bits set");
   a_plain_quiet: assert property (@(posedge i_mclk) disable iff (i_reset)
      !ir_r && !$past(ir_r, 2) |-> o_sir_out_n) else $error("ir pin busy in plain mode");
   a_ir_quiet: assert property (@(posedge i_mclk) disable iff (i_reset)
      ir_r && $past(ir_r, 2) |-> o_sout) else $error("plain pin busy in ir mode");
   a_bit_length: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(o_sout) |-> low_r % BIT == 0) else $error("low run not whole bits");
   a_ir_pulse: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(o_sir_out_n) |-> pulse_r == IR_PULSE_TK * BAUD_DV) else $error("ir pulse width");
   a_tx_after_write: assert property (@(posedge i_mclk) disable iff (i_reset)
      $fell(o_sout) || $fell(o_sir_out_n) |-> sent_r) else $error("frame without write");
   a_irq_masked: assert property (@(posedge i_mclk) disable iff (i_reset)
      mask_r == 0 && $past(mask_r) == 0 |-> !o_irq) else $error("irq while all masked");
endmodule : usdp_data_port_props

bind usdp_data_port usdp_data_port_props #(.DEPTH(DEPTH), .BAUD_DV(BAUD_DV)) u_props (
   .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_sin(i_sin), .i_sir_in(i_sir_in),
   .o_sout(o_sout), .o_sir_out_n(o_sir_out_n));

// *** test/usdp_remote.sv ***
// usdp_remote: behavioural far-end serial device, 8N1 lsb first
// assumes the bench calls send and reads rxq hierarchically
`timescale 1ns/1ns
module usdp_remote
   import usdp_pkg::*;
#(
   parameter int BAUD_DV = 2
) (
   input  wire logic i_mclk,
   input  wire logic i_sout,
   input  wire logic i_sir_out_n,
   output logic      o_sin,
   output logic      o_sir_in
);
   localparam int BIT = OVS_TICKS * BAUD_DV;
   logic [7:0] rxq[$];
   logic [7:0] sh;
   logic       line;
   logic       zero_seen;
   // the unused output is held high, so one and-gate serves both modes
   assign line = i_sout & i_sir_out_n;
   initial begin
      o_sin    = 1'b1;
      o_sir_in = 1'b0;
   end
   // one frame; an ir zero is a high pulse in the first 3/16 of the bit
   task automatic send(input logic ir, input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int k = 0; k < 10; k++) begin
         for (int c = 0; c < BIT; c++) begin
            @(posedge i_mclk);
            o_sin    <= ir | fr[k];
            o_sir_in <= ir & !fr[k] & (c < IR_PULSE_TK * BAUD_DV);
         end
      end
   endtask : send
   // any low sample inside a bit window reads as zero, plain or ir
   always begin
      @(negedge line);
      for (int k = 0; k < 9; k++) begin
         zero_seen = 1'b0;
         repeat (BIT) begin
            @(posedge i_mclk);
            zero_seen = zero_seen | !line;
         end
         if (k > 0) sh = {!zero_seen, sh[7:1]};
      end
      rxq.push_back(sh);
   end
endmodule : usdp_remote

// *** test/usdp_data_port_tb_top.sv ***
// usdp_data_port_tb_top: self-checking bench of the serial data port
// assumes the remote line model and the bound port checker
`timescale 1ns/1ns
module usdp_data_port_tb_top
   import usdp_pkg::*;
;
   localparam int DP = 4;  // short fifo keeps overflow runs brief
   localparam int DV = 2;  // fast baud, 32 clocks a bit
   logic        i_mclk  = 1'b0;
   logic        i_reset = 1'b1;
   logic        i_wr    = 1'b0;
   logic        i_rd    = 1'b0;
   logic [31:0] i_addr  = 32'h0;
   logic [31:0] i_wdata = 32'h0;
   logic [31:0] o_rdata, q;
   logic        i_sin, i_sir_in, o_irq, o_sout, o_sir_out_n;
   int          errors = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   // ****
   // clock, design and far end
   // ****
   always #5 i_mclk = ~i_mclk;
   usdp_data_port #(.DEPTH(DP), .BAUD_DV(DV)) uut (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_sin(i_sin), .i_sir_in(i_sir_in),
      .o_sout(o_sout), .o_sir_out_n(o_sir_out_n));
   usdp_remote #(.BAUD_DV(DV)) u_rem (.i_mclk(i_mclk), .i_sout(o_sout),
      .i_sir_out_n(o_sir_out_n), .o_sin(i_sin), .o_sir_in(i_sir_in));
   // window alias k, wrapped into the sixteen words
   function automatic logic [31:0] win(input logic [31:0] k);
      return ALIAS_FIRST + {26'h0, k[3:0], 2'h0};
   endfunction : win
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // writes leave the strobe up so bursts run back to back; idle drops it
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_mclk);
   endtask : wr
   task automatic idle;
      i_wr <= 1'b0;
      @(posedge i_mclk);
   endtask : idle
   // read data stand one cycle only, so take them mid-cycle
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      i_wr   <= 1'b0;
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
      d = o_rdata;
      @(posedge i_mclk);
   endtask : rd
   task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, q);
      chk(q & m, e);
   endtask : rchk
   task automatic wait_bit(input int n);
      for (int i = 0; i < 2000; i++) begin
         rd(LINE_STAT_A, q);
         if (q[n] === 1'b1) break;
      end
      chk({31'h0, q[n]}, 32'h1);
   endtask : wait_bit
   task automatic irq_is(input logic e);
      idle();
      @(negedge i_mclk);
      chk({31'h0, o_irq}, {31'h0, e});
      @(posedge i_mclk);
   endtask : irq_is
   task automatic wrap_up;
      if (errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   // cycle ceiling; the run needs about 4500 cycles
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         wrap_up();
      end
   end
   // ****
   // scenarios
   // ****
   initial begin
      logic [7:0] b[6];
      void'($urandom(46));
      foreach (b[i]) b[i] = 8'($urandom);
      b[0] = 8'h00;  // corner bytes: all zero, all one
      b[1] = 8'hFF;
      repeat (2) @(posedge i_mclk);
      i_reset <= 1'b0;
      @(posedge i_mclk);
      rchk(SHADOW_13, 32'hFFFF_FFFF, 32'h0);
      rchk(SHADOW_14, 32'hFFFF_FFFF, 32'h0);
      rchk(ALIAS_LAST + 32'h4, 32'hFFFF_FFFF, 32'h0);
      rchk(LINE_STAT_A, 32'h63, 32'h60);
      // fifos off: an unread byte is overwritten
      u_rem.send(1'b0, b[0]);
      rchk(LINE_STAT_A, 32'h3, 32'h1);
      u_rem.send(1'b0, b[1]);
      rchk(LINE_STAT_A, 32'h3, 32'h3);
      rchk(win($urandom), 32'hFFFF_FFFF, {24'h0, b[1]});
      rchk(LINE_STAT_A, 32'h3, 32'h0);
      // events are silent while masked, then raise and clear the line
      irq_is(1'b0);
      wr(IRQ_MASK_A, 32'h3);
      irq_is(1'b1);
      wr(IRQ_STAT_A, 32'h7);
      irq_is(1'b0);
      // fifos on, infrared: a full receive fifo drops the next byte
      wr(FIFO_CTRL_A, 32'h1);
      wr(MODE_CTRL_A, 32'h1);
      idle();
      for (int i = 0; i <= DP; i++) u_rem.send(1'b1, b[i]);
      rchk(LINE_STAT_A, 32'h3, 32'h3);
      for (int i = 0; i < DP; i++) rchk(win($urandom), 32'hFF, {24'h0, b[i]});
      rchk(LINE_STAT_A, 32'h1, 32'h0);
      // fifos off, plain: a second pending byte replaces the first
      wr(MODE_CTRL_A, 32'h0);
      wr(FIFO_CTRL_A, 32'h0);
      wr(win($urandom), {24'h0, b[2]});
      idle();
      wait_bit(LS_TXHOLD);
      wr(win($urandom), {24'h0, b[3]});
      idle();
      rchk(LINE_STAT_A, 32'h20, 32'h0);
      wr(win($urandom), {24'h0, b[4]});
      idle();
      wait_bit(LS_TEMT);
      chk(32'(u_rem.rxq.size()), 32'h2);
      chk({24'h0, u_rem.rxq.pop_front()}, {24'h0, b[2]});
      chk({24'h0, u_rem.rxq.pop_front()}, {24'h0, b[4]});
      // fifos on, infrared: a busy shifter lets the fifo fill to DP
      wr(MODE_CTRL_A, 32'h1);
      wr(FIFO_CTRL_A, 32'h1);
      wr(win($urandom), {24'h0, b[5]});
      idle();
      wait_bit(LS_TXHOLD);
      for (int i = 0; i <= DP; i++) wr(win(i + 13), {24'h0, b[i]});
      idle();
      wait_bit(LS_TEMT);
      chk(32'(u_rem.rxq.size()), 32'(DP + 1));
      chk({24'h0, u_rem.rxq.pop_front()}, {24'h0, b[5]});
      for (int i = 0; i < DP; i++) chk({24'h0, u_rem.rxq.pop_front()}, {24'h0, b[i]});
      wrap_up();
   end
endmodule : usdp_data_port_tb_top
